// ===== src/recovery_freq_pkg.sv
// constants for the recovery frequency selection block
// assumes a byte-wide register port driven by the serial interface engine
// Summary of operation
// R01 - Divider settings covering outputs from 50 MHz to 248 MHz are all accepted and stored.
// R02 - Any write to the recovery N or M register retunes the output without waiting for the other.
// R03 - The host should write N and M in one word or block write to avoid a mixed pair; each byte here still retunes, so a mixed pair lasts one byte.
// R04 - Bit 7 of the M register selects the recovery source: 0 strap choice, 1 programmed dividers.
// R05 - A watchdog time-out switches the output to the selected recovery frequency on its own.
// R06 - With the source bit set, the recovery frequency comes from the 8-bit N and 7-bit M fields.
// R07 - The clock ratio follows the latched strap choice unless ratio override selects the software code.
// R08 - The recovery N and M values go to the synthesizer unchanged as divider parameters.
package recovery_freq_pkg;
    localparam logic [7:0] OFS_RECOVERY_N    = 8'h0B;
    localparam logic [7:0] OFS_RECOVERY_M    = 8'h0C;
    localparam logic [7:0] RST_RECOVERY_N    = 8'h00;
    localparam logic [7:0] RST_RECOVERY_M    = 8'h00;
    localparam logic [7:0] READ_UNMAPPED     = 8'h00;
    localparam int         SRC_SELECT_BIT    = 7;
    localparam int         M_FIELD_MSB       = 6;
    localparam int         N_WIDTH           = 8;
    localparam int         M_WIDTH           = 7;
    localparam int         CHOICE_WIDTH      = 5;
    localparam logic [4:0] RST_CHOICE        = 5'h00;
    localparam int         OUT_FREQ_MIN_MHZ  = 50;
    localparam int         OUT_FREQ_MAX_MHZ  = 248;

    typedef enum logic [1:0] {
        ST_NORMAL  = 2'b01,
        ST_RECOVER = 2'b10
    } mode_t;
endpackage

// ===== src/recovery_freq_select.sv
// recovery divider registers, domain crossing and recovery source selection
// assumes the serial interface engine presents decoded byte writes on LINK_CLK,
// and that watchdog time-out and ratio controls come from logic on CLK
module recovery_freq_select
    import recovery_freq_pkg::*;
(
    // core clock and reset
    input  wire logic                    CLK,
    input  wire logic                    RST_B,
    // register port on the serial interface clock
    input  wire logic                    LINK_CLK,
    input  wire logic [7:0]              REG_ADDR,
    input  wire logic                    REG_WR_EN,
    input  wire logic [7:0]              REG_WDATA,
    output logic      [7:0]              REG_RDATA,
    // strap pins and ratio control
    input  wire logic [CHOICE_WIDTH-1:0] STRAP_FREQUENCY_CHOICE,
    input  wire logic                    RATIO_OVERRIDE,
    input  wire logic [CHOICE_WIDTH-1:0] SW_RATIO_CODE,
    // watchdog events
    input  wire logic                    WATCHDOG_TIMEOUT,
    input  wire logic                    RECOVERY_CLEAR,
    // synthesizer side
    output logic                         RECOVERY_ACTIVE,
    output logic                         USE_DIVIDERS,
    output logic [N_WIDTH-1:0]           RECOVERY_DIVIDER_N,
    output logic [M_WIDTH-1:0]           RECOVERY_DIVIDER_M,
    output logic                         DIVIDER_LOAD,
    output logic [CHOICE_WIDTH-1:0]      RECOVERY_CHOICE,
    output logic [CHOICE_WIDTH-1:0]      RATIO_CODE
);

    typedef struct packed {
        logic [7:0] n_reg;
        logic [7:0] m_reg;
        logic       req_reg;
        logic [7:0] rdata_reg;
    } link_state_t;

    typedef struct packed {
        logic [2:0]              req_sync_reg;
        logic [CHOICE_WIDTH-1:0] strap_s1_reg;
        logic [CHOICE_WIDTH-1:0] strap_s2_reg;
        logic [1:0]              strap_fill_reg;
        logic                    strap_taken_reg;
        logic [CHOICE_WIDTH-1:0] strap_latched_reg;
        logic [N_WIDTH-1:0]      n_reg;
        logic [M_WIDTH-1:0]      m_reg;
        logic                    src_sel_reg;
        mode_t                   mode_reg;
        logic                    load_reg;
        logic [CHOICE_WIDTH-1:0] ratio_reg;
    } core_state_t;

    link_state_t link_reg;
    link_state_t link_next;
    core_state_t core_reg;
    core_state_t core_next;
    logic        req_edge;
    logic        wr_n;
    logic        wr_m;

    // link side: byte writes to N or M land in the registers, each one toggles a request
    assign wr_n = REG_WR_EN && (REG_ADDR == OFS_RECOVERY_N);
    assign wr_m = REG_WR_EN && (REG_ADDR == OFS_RECOVERY_M);

    always_comb
    begin
        link_next = link_reg;
        if (wr_n)
        begin
            link_next.n_reg = REG_WDATA; // R01
        end
        if (wr_m)
        begin
            link_next.m_reg = REG_WDATA; // R04
        end
        // one toggle per write, so N alone or M alone is forwarded
        if (wr_n || wr_m)
        begin
            link_next.req_reg = ~link_reg.req_reg; // R02
        end
        // read data registered; unmapped bytes read as zero
        if (REG_ADDR == OFS_RECOVERY_N)
        begin
            link_next.rdata_reg = link_reg.n_reg;
        end
        else if (REG_ADDR == OFS_RECOVERY_M)
        begin
            link_next.rdata_reg = link_reg.m_reg;
        end
        else
        begin
            link_next.rdata_reg = READ_UNMAPPED;
        end
    end

    always_ff @(posedge LINK_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            link_reg.n_reg     <= RST_RECOVERY_N;
            link_reg.m_reg     <= RST_RECOVERY_M;
            link_reg.req_reg   <= 1'b0;
            link_reg.rdata_reg <= READ_UNMAPPED;
        end
        else
        begin
            link_reg <= link_next;
        end
    end

    assign REG_RDATA = link_reg.rdata_reg;

    // core side: the request toggle passes two flops before the edge detector
    // the register bytes are only sampled once the toggle has settled; the
    // link clock is far slower than the core, so they cannot move meanwhile
    assign req_edge = core_reg.req_sync_reg[2] ^ core_reg.req_sync_reg[1];

    always_comb
    begin
        core_next = core_reg;
        core_next.req_sync_reg = {core_reg.req_sync_reg[1:0], link_reg.req_reg};
        core_next.strap_s1_reg = STRAP_FREQUENCY_CHOICE;
        core_next.strap_s2_reg = core_reg.strap_s1_reg;
        core_next.load_reg     = 1'b0;
        // fill marker walks behind the pin synchroniser; only the second
        // stage is latched, so a pin caught mid-change cannot leak in
        core_next.strap_fill_reg = {core_reg.strap_fill_reg[0], 1'b1};
        // strap caught once, after the pin synchroniser has filled
        if (!core_reg.strap_taken_reg && core_reg.strap_fill_reg[1])
        begin
            core_next.strap_taken_reg   = 1'b1;                  // R07
            core_next.strap_latched_reg = core_reg.strap_s2_reg; // R04 R07
        end
        // divider values forwarded untouched to the synthesizer
        if (req_edge)
        begin
            core_next.n_reg       = link_reg.n_reg;                      // R06 R08
            core_next.m_reg       = link_reg.m_reg[M_FIELD_MSB:0];       // R06 R08
            core_next.src_sel_reg = link_reg.m_reg[SRC_SELECT_BIT];      // R04
            core_next.load_reg    = 1'b1;                                // R02
        end
        unique case (core_reg.mode_reg)
            ST_NORMAL:
            begin
                if (WATCHDOG_TIMEOUT)
                begin
                    core_next.mode_reg = ST_RECOVER; // R05
                    core_next.load_reg = 1'b1;       // R05
                end
            end
            ST_RECOVER:
            begin
                if (RECOVERY_CLEAR && !WATCHDOG_TIMEOUT)
                begin
                    core_next.mode_reg = ST_NORMAL;
                end
            end
            default:
            begin
                core_next.mode_reg = ST_NORMAL;
            end
        endcase
        // ratio source follows the override bit
        core_next.ratio_reg = RATIO_OVERRIDE ? SW_RATIO_CODE
                                             : core_reg.strap_latched_reg; // R07
    end

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            core_reg.req_sync_reg      <= 3'h0;
            core_reg.strap_s1_reg      <= RST_CHOICE;
            core_reg.strap_s2_reg      <= RST_CHOICE;
            core_reg.strap_fill_reg    <= 2'h0;
            core_reg.strap_taken_reg   <= 1'b0;
            core_reg.strap_latched_reg <= RST_CHOICE;
            core_reg.n_reg             <= RST_RECOVERY_N;
            core_reg.m_reg             <= RST_RECOVERY_M[M_FIELD_MSB:0];
            core_reg.src_sel_reg       <= RST_RECOVERY_M[SRC_SELECT_BIT];
            core_reg.mode_reg          <= ST_NORMAL;
            core_reg.load_reg          <= 1'b0;
            core_reg.ratio_reg         <= RST_CHOICE;
        end
        else
        begin
            core_reg <= core_next;
        end
    end

    // outputs from core flops; RECOVERY_ACTIVE and USE_DIVIDERS are decoded from them
    assign RECOVERY_ACTIVE    = core_reg.mode_reg == ST_RECOVER;
    assign USE_DIVIDERS       = RECOVERY_ACTIVE && core_reg.src_sel_reg; // R04 R06
    assign RECOVERY_DIVIDER_N = core_reg.n_reg;
    assign RECOVERY_DIVIDER_M = core_reg.m_reg;
    assign DIVIDER_LOAD       = core_reg.load_reg;
    assign RECOVERY_CHOICE    = core_reg.strap_latched_reg;
    assign RATIO_CODE         = core_reg.ratio_reg;

    chk_write_loads_divider: assert property ( // R02
        @(posedge CLK) disable iff (!RST_B)
        req_edge |=> DIVIDER_LOAD)
        else $error("divider write did not pulse load");

    chk_n_passed_through: assert property ( // R08
        @(posedge CLK) disable iff (!RST_B)
        req_edge |=> RECOVERY_DIVIDER_N == $past(link_reg.n_reg))
        else $error("recovery N changed on its way to the synthesizer");

    chk_m_field_width: assert property ( // R06
        @(posedge CLK) disable iff (!RST_B)
        req_edge |=> RECOVERY_DIVIDER_M == $past(link_reg.m_reg[M_FIELD_MSB:0]))
        else $error("recovery M field not taken from bits 6 to 0");

    chk_source_bit: assert property ( // R04
        @(posedge CLK) disable iff (!RST_B)
        req_edge |=> core_reg.src_sel_reg == $past(link_reg.m_reg[SRC_SELECT_BIT]))
        else $error("source select not taken from bit 7");

    chk_timeout_switch: assert property ( // R05
        @(posedge CLK) disable iff (!RST_B)
        (WATCHDOG_TIMEOUT && !RECOVERY_ACTIVE) |=> (RECOVERY_ACTIVE && DIVIDER_LOAD))
        else $error("time-out did not switch to recovery");

    chk_divider_use: assert property ( // R06
        @(posedge CLK) disable iff (!RST_B)
        ($rose(RECOVERY_ACTIVE) && !$past(req_edge)) |-> USE_DIVIDERS == $past(core_reg.src_sel_reg))
        else $error("recovery entry did not follow the stored source bit");

    chk_ratio_override: assert property ( // R07
        @(posedge CLK) disable iff (!RST_B)
        RATIO_OVERRIDE ##1 $stable(SW_RATIO_CODE) |-> RATIO_CODE == SW_RATIO_CODE)
        else $error("ratio ignores software code under override");

    chk_ratio_strap: assert property ( // R07
        @(posedge CLK) disable iff (!RST_B)
        !$past(RATIO_OVERRIDE) |-> RATIO_CODE == $past(core_reg.strap_latched_reg))
        else $error("ratio ignores latched strap choice");

    chk_full_n_range: assert property ( // R01
        @(posedge CLK) disable iff (!RST_B)
        DIVIDER_LOAD && $past(req_edge) |-> $past(link_reg.n_reg) == RECOVERY_DIVIDER_N)
        else $error("programmed N value limited");

    // recovery mode exit, and the time-out holding it
    chk_clear_leaves: assert property ( // R05
        @(posedge CLK) disable iff (!RST_B)
        (RECOVERY_ACTIVE && RECOVERY_CLEAR && !WATCHDOG_TIMEOUT) |=> !RECOVERY_ACTIVE)
        else $error("clear did not leave recovery");

    chk_timeout_wins: assert property ( // R05
        @(posedge CLK) disable iff (!RST_B)
        (RECOVERY_ACTIVE && WATCHDOG_TIMEOUT) |=> RECOVERY_ACTIVE)
        else $error("recovery left while time-out still asserted");

    chk_source_joint: assert property ( // R04
        @(posedge CLK) disable iff (!RST_B)
        req_edge |=> USE_DIVIDERS == (RECOVERY_ACTIVE && $past(link_reg.m_reg[SRC_SELECT_BIT])))
        else $error("divider use does not follow the new source bit");

    // retune pulses only for a divider write or a recovery entry
    chk_load_has_cause: assert property ( // R02
        @(posedge CLK) disable iff (!RST_B)
        DIVIDER_LOAD |-> ($past(req_edge) || $rose(RECOVERY_ACTIVE)))
        else $error("retune pulse without a cause");

    chk_dividers_held: assert property ( // R08
        @(posedge CLK) disable iff (!RST_B)
        !$past(req_edge) |-> ($stable(RECOVERY_DIVIDER_N) && $stable(RECOVERY_DIVIDER_M)))
        else $error("divider outputs moved without a write");

    // strap choice caught once from the second synchroniser stage
    chk_strap_latched: assert property ( // R04
        @(posedge CLK) disable iff (!RST_B)
        $rose(core_reg.strap_taken_reg) |-> RECOVERY_CHOICE == $past(core_reg.strap_s2_reg))
        else $error("strap choice not taken from the synchroniser");

    chk_strap_held: assert property ( // R07
        @(posedge CLK) disable iff (!RST_B)
        core_reg.strap_taken_reg |=> $stable(RECOVERY_CHOICE))
        else $error("latched strap choice moved");

    // register port on the serial interface clock
    chk_n_write_stored: assert property ( // R01
        @(posedge LINK_CLK) disable iff (!RST_B)
        wr_n |=> link_reg.n_reg == $past(REG_WDATA))
        else $error("N byte not stored as written");

    chk_m_write_stored: assert property ( // R04
        @(posedge LINK_CLK) disable iff (!RST_B)
        wr_m |=> link_reg.m_reg == $past(REG_WDATA))
        else $error("M byte not stored as written");

    chk_write_toggles: assert property ( // R02
        @(posedge LINK_CLK) disable iff (!RST_B)
        (wr_n || wr_m) |=> link_reg.req_reg != $past(link_reg.req_reg))
        else $error("divider write raised no request");

    chk_m_read_back: assert property ( // R04
        @(posedge LINK_CLK) disable iff (!RST_B)
        (REG_ADDR == OFS_RECOVERY_M) |=> REG_RDATA == $past(link_reg.m_reg))
        else $error("M byte read back wrong");

    chk_n_read_back: assert property ( // R06
        @(posedge LINK_CLK) disable iff (!RST_B)
        (REG_ADDR == OFS_RECOVERY_N) |=> REG_RDATA == $past(link_reg.n_reg))
        else $error("N byte read back wrong");

endmodule

// ===== tb/smbus_host_model.sv
// host side model: byte writes, word writes and reads on the register port
// assumes the bench runs LINK_CLK and calls these tasks hierarchically
module smbus_host_model
    import recovery_freq_pkg::*;
(
    // serial side clock
    input  wire logic       LINK_CLK,
    // register port toward the device
    output logic      [7:0] REG_ADDR,
    output logic            REG_WR_EN,
    output logic      [7:0] REG_WDATA,
    input  wire logic [7:0] REG_RDATA
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle bus at time zero
    initial
    begin
        REG_ADDR  = 8'h00;
        REG_WR_EN = 1'b0;
        REG_WDATA = 8'h00;
    end

    // released data shows the inverse so a stale copy cannot pass
    task automatic release_bus();
        @(posedge LINK_CLK);
        REG_WR_EN <= 1'b0;
        REG_WDATA <= ~REG_WDATA;
    endtask

    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge LINK_CLK);
        REG_ADDR  <= a;
        REG_WR_EN <= 1'b1;
        REG_WDATA <= d;
    endtask

    task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
        put(a, d);
        release_bus();
    endtask

    // both dividers back to back so a mixed pair lasts one byte only
    task automatic write_word(input logic [7:0] n, input logic [7:0] m);
        put(OFS_RECOVERY_N, n);
        put(OFS_RECOVERY_M, m);
        release_bus();
    endtask

    // read data is valid after the edge that samples the address
    task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
        @(posedge LINK_CLK);
        REG_ADDR <= a;
        @(posedge LINK_CLK);
        #1 d = REG_RDATA;
    endtask
endmodule

// ===== tb/watchdog_recovery_freq_select_tb.sv
// self-checking bench for the recovery frequency selection block
// assumes the design and host model files are compiled first
module watchdog_recovery_freq_select_tb
    import recovery_freq_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic       clk, rst_b, link_clk, ovr, wd, clr, wr_en;
    logic       active, use_div, load;
    logic [4:0] strap, sw_ratio, choice, ratio;
    logic [7:0] addr, wdata, rdata, rd, div_n;
    logic [6:0] div_m;
    int         error_cnt = 0;
    int         checks_done = 0;
    int         load_cnt = 0;

    recovery_freq_select recovery_freq_select_inst (
        .CLK(clk), .RST_B(rst_b), .LINK_CLK(link_clk), .REG_ADDR(addr),
        .REG_WR_EN(wr_en), .REG_WDATA(wdata), .REG_RDATA(rdata),
        .STRAP_FREQUENCY_CHOICE(strap), .RATIO_OVERRIDE(ovr), .SW_RATIO_CODE(sw_ratio),
        .WATCHDOG_TIMEOUT(wd), .RECOVERY_CLEAR(clr), .RECOVERY_ACTIVE(active),
        .USE_DIVIDERS(use_div), .RECOVERY_DIVIDER_N(div_n), .RECOVERY_DIVIDER_M(div_m),
        .DIVIDER_LOAD(load), .RECOVERY_CHOICE(choice), .RATIO_CODE(ratio));

    smbus_host_model smbus_host_model_inst (
        .LINK_CLK(link_clk), .REG_ADDR(addr), .REG_WR_EN(wr_en),
        .REG_WDATA(wdata), .REG_RDATA(rdata));

    // core clock, and a link clock of unrelated phase
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        link_clk = 1'b0;
        #13;
        forever #32 link_clk = ~link_clk;
    end

    // retune pulses are counted, not just seen once
    always @(posedge clk)
        if (load === 1'b1)
            load_cnt++;

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask

    // bounded wait, then room for any stray extra pulse
    task automatic wait_loads(input int n);
        int i;
        for (i = 0; i < 40 && load_cnt < n; i++)
            @(posedge clk);
        repeat (10) @(posedge clk);
    endtask

    task automatic fire(input logic t, input logic c);
        @(posedge clk);
        wd  <= t;
        clr <= c;
        @(posedge clk);
        wd  <= 1'b0;
        clr <= 1'b0;
        #1;
    endtask

    task automatic results();
        if (error_cnt == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        #200000;
        error_cnt++;
        results();
    end

    initial
    begin
        rst_b = 1'b0;
        strap = 5'h13;
        ovr = 1'b0;
        sw_ratio = 5'h0A;
        wd = 1'b0;
        clr = 1'b0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk("choice", 8'h13, {3'h0, choice});
        chk("ratio strap", 8'h13, {3'h0, ratio});
        @(posedge clk);
        ovr <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk("ratio sw", 8'h0A, {3'h0, ratio});
        smbus_host_model_inst.read_byte(OFS_RECOVERY_N, rd);
        chk("n reset", RST_RECOVERY_N, rd);
        smbus_host_model_inst.read_byte(OFS_RECOVERY_M, rd);
        chk("m reset", RST_RECOVERY_M, rd);
        // a write elsewhere must not retune
        smbus_host_model_inst.write_byte(8'h0D, 8'h5A);
        wait_loads(1);
        chk("stray load", 8'h00, 8'(load_cnt));
        smbus_host_model_inst.read_byte(8'h0D, rd);
        chk("unmapped", READ_UNMAPPED, rd);
        // a lone M byte retunes without N
        smbus_host_model_inst.write_byte(OFS_RECOVERY_M, 8'h85);
        wait_loads(1);
        chk("load m", 8'h01, 8'(load_cnt));
        chk("div m", 8'h05, {1'b0, div_m});
        chk("div n", 8'h00, div_n);
        smbus_host_model_inst.read_byte(OFS_RECOVERY_M, rd);
        chk("m back", 8'h85, rd);
        // top values in one word, each byte retunes
        smbus_host_model_inst.write_word(8'hFF, 8'hFF);
        wait_loads(3);
        chk("load word", 8'h03, 8'(load_cnt));
        chk("div n max", 8'hFF, div_n);
        chk("div m max", 8'h7F, {1'b0, div_m});
        fire(1'b1, 1'b0);
        chk("active", 8'h01, {7'h0, active});
        chk("use div", 8'h01, {7'h0, use_div});
        chk("entry load", 8'h01, {7'h0, load});
        fire(1'b0, 1'b1);
        chk("cleared", 8'h00, {7'h0, active});
        // source bit clear: strap choice is the recovery frequency
        smbus_host_model_inst.write_byte(OFS_RECOVERY_M, 8'h22);
        wait_loads(5);
        fire(1'b1, 1'b0);
        chk("active 2", 8'h01, {7'h0, active});
        chk("use strap", 8'h00, {7'h0, use_div});
        chk("choice rec", 8'h13, {3'h0, choice});
        chk("div m 2", 8'h22, {1'b0, div_m});
        // time-out in recovery is refused, and it wins over a clear
        fire(1'b1, 1'b1);
        chk("held", 8'h01, {7'h0, active});
        chk("refused load", 8'h00, {7'h0, load});
        fire(1'b0, 1'b1);
        chk("cleared 2", 8'h00, {7'h0, active});
        results();
    end
endmodule
